// *** cpc_pkg.sv ***
// constants and types for the configurable pulse counter
package cpc_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
    // glitch filter lengths: high passes 10 kHz, low rejects noise
    localparam int unsigned FILT_HI_NS      = 20_000;
    localparam int unsigned FILT_LO_NS      = 1_000_000;
    localparam int unsigned FILT_HI_CYC     = (FILT_HI_NS + 9) / 10;
    localparam int unsigned FILT_LO_CYC     = (FILT_LO_NS + 9) / 10;
    localparam logic [15:0] RATE_MS_RST     = 16'h03E8;
    localparam logic signed [15:0] UPPER_RST = 16'sh7FFF;
    localparam logic signed [15:0] LOWER_RST = 16'sh0000;
    localparam logic signed [15:0] ON_RST    = 16'sh7FFF;
    localparam logic signed [15:0] OFF_RST   = 16'sh0000;
    localparam logic signed [15:0] LOAD_RST  = 16'sh0000;
    localparam int unsigned NUM_WORDS       = 15;
    localparam int unsigned NUM_BITS        = 16;
    // status bit positions
    localparam int unsigned ST_OUT          = 0;
    localparam int unsigned ST_CNT_IN       = 1;
    localparam int unsigned ST_SEC_IN       = 2;
    localparam int unsigned ST_ENABLED      = 3;
    localparam int unsigned ST_STROBED      = 4;
    // control bit positions
    localparam int unsigned CT_OUT_EN       = 0;
    localparam int unsigned CT_STB_CLR     = 1;
    // return word positions
    localparam int unsigned W_ACC           = 0;
    localparam int unsigned W_STROBE        = 1;
    localparam int unsigned W_RATE          = 2;
    localparam int unsigned W_TYPE          = 3;
    // counter type code, arbitrary value
    localparam logic [15:0] SINGLE_COUNTER_TYPE = 16'h0001;
    typedef enum logic [1:0] {CPC_FAIL_NORMAL, CPC_FAIL_OFF, CPC_FAIL_HOLD} cpc_fail_e;
endpackage

// *** cpc_counter.sv ***
// single unidirectional pulse counter with limits, presets and rate
`timescale 1ns/1ns
// What this block does
// - stays disabled until enable configured
// - cpu stop output follows failure mode
// - count filter high default, low rejects noise
// - second input preload, select makes strobe
// - strobe mode forces second filter high
// - second input filter selectable, high default
// - direction up or down, up default
// - continuous passes upper, reloads lower
// - one-shot stops at the limit
// - rate interval in ms, default 1000
// - upper bound default 32767
// - lower bound default zero
// - on point turns output on if enabled
// - off point turns output off, default zero
// - preload loads load value
// - status bits supplied each scan
// - return words include accumulator and capture
// - counter type fixed, informational only
// - counts per interval of last interval
// - between points take lower point state
module cpc_counter
    import cpc_pkg::*;
#(
    parameter int unsigned MS_CYC  = MS_CYCLES,
    parameter int unsigned FLT_HI  = FILT_HI_CYC,
    parameter int unsigned FLT_LO  = FILT_LO_CYC
)(
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    // field pins
    input  wire logic                       count_pin,
    input  wire logic                       second_pin,
    output logic                            count_out,
    // configuration
    input  wire logic                       cfg_enable,
    input  wire cpc_pkg::cpc_fail_e         output_failure_mode,
    input  wire logic                       count_input_filter,
    input  wire logic                       second_input_function_select,
    input  wire logic                       second_input_filter,
    input  wire logic                       count_direction,
    input  wire logic                       counting_mode,
    input  wire logic [15:0]                rate_interval,
    input  wire logic signed [15:0]         upper_bound,
    input  wire logic signed [15:0]         lower_bound,
    input  wire logic signed [15:0]         output_on_point,
    input  wire logic signed [15:0]         output_off_point,
    input  wire logic signed [15:0]         load_value,
    // controller scan exchange
    input  wire logic                       cpu_stopped,
    input  wire logic [15:0]                control_bits,
    output logic [15:0]                     status_bits,
    output logic [15:0]                     return_words [NUM_WORDS]
);
    // ----------------------------------------------------------------
    // input synchronisers and filters
    // ----------------------------------------------------------------
    logic [1:0]  sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [1:0]  filt_ff, nxt_filt, filt_lo;
    logic [16:0] fcnt_ff [2];
    logic [16:0] nxt_fcnt [2];

    // strobe mode overrides the second filter setting
    assign filt_lo[0] = count_input_filter;
    assign filt_lo[1] = second_input_filter & ~second_input_function_select;

    always_comb
    begin
        nxt_sync1 = {second_pin, count_pin};
        nxt_sync2 = sync1_ff;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_filt
            always_comb
            begin
                nxt_filt[g] = filt_ff[g];
                nxt_fcnt[g] = 17'h00000;
                if (sync2_ff[g] != filt_ff[g])
                begin
                    nxt_fcnt[g] = fcnt_ff[g] + 17'h00001;
                    if (nxt_fcnt[g] >= (filt_lo[g] ? 17'(FLT_LO) : 17'(FLT_HI)))
                    begin
                        nxt_filt[g] = sync2_ff[g];
                        nxt_fcnt[g] = 17'h00000;
                    end
                end
            end
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    filt_ff[g] <= 1'b0;
                    fcnt_ff[g] <= 17'h00000;
                end
                else
                begin
                    filt_ff[g] <= nxt_filt[g];
                    fcnt_ff[g] <= nxt_fcnt[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_ff <= 2'b00;
            sync2_ff <= 2'b00;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // ----------------------------------------------------------------
    // accumulator, strobe capture and rate
    // ----------------------------------------------------------------
    logic               prev_ff, nxt_prev;
    logic signed [15:0] acc_ff, nxt_acc, cap_ff, nxt_cap, rate_ff, nxt_rate;
    logic signed [15:0] ivl_ff, nxt_ivl;
    logic [16:0]        tick_ff, nxt_tick;
    logic [15:0]        ms_ff, nxt_ms;
    logic               stb_flag_ff, nxt_stb_flag, out_ff, nxt_out;
    logic               cnt_edge, sec_edge, sec_prev_ff, nxt_sec_prev;
    logic signed [16:0] step;

    assign cnt_edge = filt_ff[0] & ~prev_ff;
    assign sec_edge = filt_ff[1] & ~sec_prev_ff;

    always_comb
    begin
        nxt_prev     = filt_ff[0];
        nxt_sec_prev = filt_ff[1];
        nxt_acc      = acc_ff;
        nxt_cap      = cap_ff;
        nxt_ivl      = ivl_ff;
        nxt_rate     = rate_ff;
        nxt_tick     = tick_ff;
        nxt_ms       = ms_ff;
        nxt_stb_flag = stb_flag_ff & ~control_bits[CT_STB_CLR];
        step         = count_direction ? 17'(acc_ff) - 17'sd1
                                       : 17'(acc_ff) + 17'sd1;
        if (cfg_enable)
        begin
            if (cnt_edge)
            begin
                nxt_ivl = count_direction ? ivl_ff - 16'sh0001 : ivl_ff + 16'sh0001;
                if (counting_mode)
                begin
                    // one-shot holds at the limit in the counting direction
                    if (!(count_direction ? acc_ff <= lower_bound : acc_ff >= upper_bound))
                        nxt_acc = step[15:0];
                end
                else if (!count_direction && acc_ff >= upper_bound)
                    nxt_acc = lower_bound;
                else if (count_direction && acc_ff <= lower_bound)
                    nxt_acc = upper_bound;
                else
                    nxt_acc = step[15:0];
            end
            if (sec_edge && !second_input_function_select)
                nxt_acc = load_value;
            if (sec_edge && second_input_function_select)
            begin
                nxt_cap      = acc_ff;
                nxt_stb_flag = 1'b1;
            end
            nxt_tick = tick_ff + 17'h00001;
            if (nxt_tick >= 17'(MS_CYC))
            begin
                nxt_tick = 17'h00000;
                nxt_ms   = ms_ff + 16'h0001;
                if (nxt_ms >= rate_interval)
                begin
                    nxt_ms   = 16'h0000;
                    nxt_rate = nxt_ivl;
                    nxt_ivl  = 16'sh0000;
                end
            end
        end
    end

    // output compare, lower point decides between the points
    logic               lo_is_on, between, cmp_on;
    logic signed [15:0] p_lo, p_hi;
    always_comb
    begin
        lo_is_on = output_on_point < output_off_point;
        p_lo     = lo_is_on ? output_on_point : output_off_point;
        p_hi     = lo_is_on ? output_off_point : output_on_point;
        if (output_on_point == output_off_point)
            between = acc_ff == output_on_point;
        else if (lo_is_on)
            between = acc_ff >= p_lo && acc_ff <= p_hi;
        else
            // both points count as between, so the output is off on them
            between = acc_ff >= p_lo && acc_ff <= p_hi;
        cmp_on = (output_on_point == output_off_point) ? between
                 : (between ? lo_is_on : ~lo_is_on);
        nxt_out = cfg_enable & cmp_on & control_bits[CT_OUT_EN];
        if (cpu_stopped)
        begin
            unique case (output_failure_mode)
                CPC_FAIL_OFF:  nxt_out = 1'b0;
                CPC_FAIL_HOLD: nxt_out = out_ff;
                default:       nxt_out = cfg_enable & cmp_on & control_bits[CT_OUT_EN];
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_ff     <= 1'b0;
            sec_prev_ff <= 1'b0;
            acc_ff      <= LOAD_RST;
            cap_ff      <= 16'sh0000;
            ivl_ff      <= 16'sh0000;
            rate_ff     <= 16'sh0000;
            tick_ff     <= 17'h00000;
            ms_ff       <= 16'h0000;
            stb_flag_ff <= 1'b0;
            out_ff      <= 1'b0;
        end
        else
        begin
            prev_ff     <= nxt_prev;
            sec_prev_ff <= nxt_sec_prev;
            acc_ff      <= nxt_acc;
            cap_ff      <= nxt_cap;
            ivl_ff      <= nxt_ivl;
            rate_ff     <= nxt_rate;
            tick_ff     <= nxt_tick;
            ms_ff       <= nxt_ms;
            stb_flag_ff <= nxt_stb_flag;
            out_ff      <= nxt_out;
        end
    end

    // ----------------------------------------------------------------
    // scan exchange
    // ----------------------------------------------------------------
    assign count_out = out_ff;
    always_comb
    begin
        status_bits              = 16'h0000;
        status_bits[ST_OUT]      = out_ff;
        status_bits[ST_CNT_IN]   = filt_ff[0];
        status_bits[ST_SEC_IN]   = filt_ff[1];
        status_bits[ST_ENABLED]  = cfg_enable;
        status_bits[ST_STROBED]  = stb_flag_ff;
        for (int i = 0; i < NUM_WORDS; i++)
            return_words[i] = 16'h0000;
        return_words[W_ACC]    = acc_ff;
        return_words[W_STROBE] = cap_ff;
        return_words[W_RATE]   = rate_ff;
        return_words[W_TYPE]   = SINGLE_COUNTER_TYPE;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_disabled_frozen: assert property (!cfg_enable |=> $stable(acc_ff))
        else $error("accumulator moved while disabled");
    a_force_off: assert property (
        cpu_stopped && output_failure_mode == CPC_FAIL_OFF |=> !out_ff)
        else $error("output not forced off");
    a_hold_out: assert property (
        cpu_stopped && output_failure_mode == CPC_FAIL_HOLD |=> $stable(out_ff))
        else $error("output not held");
    a_wrap_lower: assert property (
        cfg_enable && cnt_edge && !counting_mode && !count_direction
        && acc_ff >= upper_bound && !sec_edge |=> acc_ff == $past(lower_bound))
        else $error("no wrap to lower bound");
    a_oneshot_stop: assert property (
        cfg_enable && counting_mode && !count_direction
        && acc_ff >= upper_bound && !sec_edge |=> acc_ff == $past(acc_ff))
        else $error("one-shot moved past limit");
    a_preload_load: assert property (
        cfg_enable && sec_edge && !second_input_function_select
        |=> acc_ff == $past(load_value))
        else $error("preload not applied");
    a_strobe_capture: assert property (
        cfg_enable && sec_edge && second_input_function_select
        |=> cap_ff == $past(acc_ff) && stb_flag_ff)
        else $error("strobe capture missed");
    a_out_enable: assert property (!control_bits[CT_OUT_EN] && !cpu_stopped |=> !out_ff)
        else $error("output on without enable");
    a_type_fixed: assert property (return_words[W_TYPE] == SINGLE_COUNTER_TYPE)
        else $error("counter type changed");

    c_wrap: cover property (cnt_edge && !counting_mode && acc_ff >= upper_bound);
    c_strobe: cover property (sec_edge && second_input_function_select);
    c_out_on: cover property (!out_ff ##1 out_ff);
    c_rate: cover property (rate_ff != 16'sh0000);
endmodule

// *** cpc_cpu_model.sv ***
// controller scan model: sends control bits, samples return data each scan
`timescale 1ns/1ns
module cpc_cpu_model
    import cpc_pkg::*;
#(
    parameter int unsigned SCAN_CYC = 4
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // wishes of the test sequence
    input  wire logic        want_out_en,
    input  wire logic        want_stb_clr,
    input  wire logic        want_stop,
    // scan exchange
    output logic             cpu_stopped,
    output logic [15:0]      control_bits,
    input  wire logic [15:0] return_words [NUM_WORDS],
    output logic [15:0]      scan_acc
);
    int unsigned tick;
    // control only moves at scan boundaries, so the counter sees sweep latency
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick <= 0;
            cpu_stopped <= 1'b0;
            control_bits <= 16'h0000;
            scan_acc <= 16'h0000;
        end
        else if (tick == SCAN_CYC - 1)
        begin
            tick <= 0;
            cpu_stopped <= want_stop;
            control_bits <= {14'h0000, want_stb_clr, want_out_en};
            scan_acc <= return_words[W_ACC];
        end
        else
            tick <= tick + 1;
    end
endmodule

// *** tb_configurable_pulse_counter.sv ***
// self-checking bench for the configurable pulse counter
`timescale 1ns/1ns
module tb_configurable_pulse_counter;
    import cpc_pkg::*;
    logic sys_clk = 0, nrst = 0, cnt_pin = 0, sec_pin = 0, en = 0, cfil = 0;
    logic sel = 0, sfil = 0, dir = 0, mode = 0, want_en = 0, want_clr = 0, want_stop = 0;
    cpc_fail_e fmode = CPC_FAIL_NORMAL;
    logic [15:0] rate = RATE_MS_RST;
    logic signed [15:0] upper = UPPER_RST, lower = LOWER_RST, on_pt = ON_RST;
    logic signed [15:0] off_pt = OFF_RST, load = LOAD_RST;
    logic count_out, cpu_stopped;
    logic [15:0] control_bits, status_bits, scan_acc;
    logic [15:0] words [NUM_WORDS];
    int errors = 0, checked = 0;
    always #5 sys_clk = ~sys_clk;
    cpc_counter #(.MS_CYC(10), .FLT_HI(2), .FLT_LO(4)) uut (
        .sys_clk(sys_clk), .nrst(nrst), .count_pin(cnt_pin), .second_pin(sec_pin),
        .count_out(count_out), .cfg_enable(en), .output_failure_mode(fmode),
        .count_input_filter(cfil), .second_input_function_select(sel),
        .second_input_filter(sfil), .count_direction(dir), .counting_mode(mode),
        .rate_interval(rate), .upper_bound(upper), .lower_bound(lower),
        .output_on_point(on_pt), .output_off_point(off_pt), .load_value(load),
        .cpu_stopped(cpu_stopped), .control_bits(control_bits),
        .status_bits(status_bits), .return_words(words));
    cpc_cpu_model cpu (
        .sys_clk(sys_clk), .nrst(nrst), .want_out_en(want_en), .want_stb_clr(want_clr),
        .want_stop(want_stop), .cpu_stopped(cpu_stopped), .control_bits(control_bits),
        .return_words(words), .scan_acc(scan_acc));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic wrap_up();
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input bit second, input int hi, input int lo);
        @(posedge sys_clk);
        if (second)
            sec_pin <= 1'b1;
        else
            cnt_pin <= 1'b1;
        repeat (hi) @(posedge sys_clk);
        sec_pin <= 1'b0;
        cnt_pin <= 1'b0;
        repeat (lo) @(posedge sys_clk);
    endtask
    task automatic count(input int n);
        repeat (n) pulse(1'b0, 6, 12);
    endtask
    task automatic pre(input logic signed [15:0] v);
        load <= v;
        pulse(1'b1, 6, 12);
    endtask
    task automatic settle();
        repeat (12) @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_disabled();
        count(2);
        chk16(words[W_ACC], 16'h0000);
        chk1(status_bits[ST_ENABLED], 1'b0);
        chk16(words[W_TYPE], SINGLE_COUNTER_TYPE);
    endtask
    task automatic t_up_and_filter();
        en <= 1'b1;
        settle();
        count(3);
        chk16(words[W_ACC], 16'h0003);
        settle();
        chk16(scan_acc, 16'h0003);
        chk1(status_bits[ST_ENABLED], 1'b1);
        cfil <= 1'b1;
        pulse(1'b0, 3, 12);
        chk16(words[W_ACC], 16'h0003);
        pulse(1'b0, 8, 12);
        chk16(words[W_ACC], 16'h0004);
        cfil <= 1'b0;
    endtask
    task automatic t_limits();
        upper <= 16'sh0005;
        lower <= -16'sh0003;
        pre(16'sh0004);
        chk16(words[W_ACC], 16'h0004);
        count(2);
        chk16(words[W_ACC], 16'hFFFD);
        dir <= 1'b1;
        count(1);
        chk16(words[W_ACC], 16'h0005);
        mode <= 1'b1;
        pre(-16'sh0002);
        count(3);
        chk16(words[W_ACC], 16'hFFFD);
        dir <= 1'b0;
        pre(16'sh0004);
        count(3);
        chk16(words[W_ACC], 16'h0005);
        mode <= 1'b0;
    endtask
    task automatic t_presets();
        logic signed [15:0] pv [9] = '{16'sh0001, 16'sh0002, 16'sh0004, 16'sh0005, 16'sh0003,
                                       16'sh0005, 16'sh0002, 16'sh0004, 16'sh0001};
        logic ov [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        want_en <= 1'b1;
        on_pt <= 16'sh0002;
        off_pt <= 16'sh0004;
        for (int i = 0; i < 9; i++)
        begin
            if (i == 4)
            begin
                on_pt <= 16'sh0004;
                off_pt <= 16'sh0002;
            end
            pre(pv[i]);
            chk1(count_out, ov[i]);
            chk1(status_bits[ST_OUT], ov[i]);
        end
        want_en <= 1'b0;
        settle();
        chk1(count_out, 1'b0);
        on_pt <= 16'sh0002;
        off_pt <= 16'sh0004;
        want_en <= 1'b1;
    endtask
    task automatic t_fail_modes();
        pre(16'sh0003);
        fmode <= CPC_FAIL_OFF;
        want_stop <= 1'b1;
        settle();
        chk1(count_out, 1'b0);
        want_stop <= 1'b0;
        settle();
        fmode <= CPC_FAIL_HOLD;
        want_stop <= 1'b1;
        settle();
        count(2);
        chk16(words[W_ACC], 16'h0005);
        chk1(count_out, 1'b1);
        want_stop <= 1'b0;
        settle();
        chk1(count_out, 1'b0);
        fmode <= CPC_FAIL_NORMAL;
        want_stop <= 1'b1;
        pre(16'sh0003);
        chk1(count_out, 1'b1);
        want_stop <= 1'b0;
    endtask
    task automatic t_strobe();
        sfil <= 1'b1;
        pulse(1'b1, 3, 12);
        chk16(words[W_ACC], 16'h0003);
        sel <= 1'b1;
        count(1);
        pulse(1'b1, 3, 12);
        chk16(words[W_STROBE], 16'h0004);
        chk16(words[W_ACC], 16'h0004);
        chk1(status_bits[ST_STROBED], 1'b1);
        want_clr <= 1'b1;
        settle();
        chk1(status_bits[ST_STROBED], 1'b0);
        want_clr <= 1'b0;
        sel <= 1'b0;
        sfil <= 1'b0;
    endtask
    task automatic t_rate();
        upper <= UPPER_RST;
        rate <= 16'h0002;
        repeat (12) pulse(1'b0, 5, 4);
        chk16(words[W_RATE], 16'h0002);
    endtask
    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        t_disabled();
        t_up_and_filter();
        t_limits();
        t_presets();
        t_fail_modes();
        t_strobe();
        t_rate();
        wrap_up();
    end
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        wrap_up();
    end
endmodule
